// *** shared/mra_min_avg_regs.vh ***
/*
 Register offsets, field positions and reset values of the minimum-search and
 running-average unit. Assumes inclusion by bare name from the design file.
*/
`ifndef MRA_MIN_AVG_REGS_VH
`define MRA_MIN_AVG_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MRA_EXEC_OFS     12'h000
`define MRA_CTRL_OFS     12'h004
`define MRA_RANGE_OFS    12'h008
`define MRA_SOURCE_OFS   12'h00C
`define MRA_NCYC_OFS     12'h010
`define MRA_MINRES_OFS   12'h014
`define MRA_MINLOC_OFS   12'h018
`define MRA_STATUS_OFS   12'h01C
`define MRA_MINCODE_OFS  12'h020
`define MRA_AVGCODE_OFS  12'h024
`define MRA_AVGRES_OFS   12'h028
`define MRA_AVGPTR_OFS   12'h02C
`define MRA_MEM_PAGE     4'h1
`define MRA_HIST_PAGE    4'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define MRA_EXEC_COND_BIT   16
`define MRA_CTRL_SIGNED_BIT 15
`define MRA_CTRL_LOC_BIT    14
`define MRA_RANGE_DM_BIT    16
`define MRA_PTR_VALID_BIT   15

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define MRA_MINCODE_RST  10'h0B7
`define MRA_AVGCODE_RST  10'h0C3
`define MRA_NCYC_RST     16'h0001
`define MRA_NCYC_MAX     14'h0040
`define MRA_RESP_OKAY    2'h0
`define MRA_RESP_SLVERR  2'h2

`endif

// *** src/mra_min_avg.v ***
/*
 Minimum search and running average execution unit with an AXI4-Lite
 register slave, a flip-flop word memory holding the search range and a
 history buffer for the average.
 Assumes one clock, an active-low asynchronous reset and a master that keeps
 one write and one read under way at a time.
*/
`timescale 1ns/1ps
`include "mra_min_avg_regs.vh"

module mra_min_avg #(
   parameter MEM_AW  = 6,
   parameter HIST_AW = 6
)(
   input  wire        clk,
   input  wire        arst_n,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   localparam [6:0] MEM_WORDS  = 7'h1 << MEM_AW;
   localparam [6:0] HIST_WORDS = 7'h1 << HIST_AW;
   localparam       SUM_W      = 16 + HIST_AW;
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_MIN  = 2'h1;
   localparam [1:0] ST_SUM  = 2'h2;
   localparam [1:0] ST_DIV  = 2'h3;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function isBcd;
      input [15:0] b;
      begin
         isBcd = (b[3:0] < 4'hA) && (b[7:4] < 4'hA) && (b[11:8] < 4'hA) && (b[15:12] < 4'hA);
      end
   endfunction

   function [13:0] bcd2bin;
      input [15:0] b;
      begin
         bcd2bin = b[15:12] * 14'h03E8 + b[11:8] * 14'h0064 + b[7:4] * 14'h000A + b[3:0];
      end
   endfunction

   function [15:0] bcdInc;
      input [15:0] b;
      reg   [15:0] r;
      reg          c;
      integer      i;
      begin
         r = b;
         c = 1'b1;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (c)
            begin
               if (r[i*4 +: 4] == 4'h9)
                  r[i*4 +: 4] = 4'h0;
               else
               begin
                  r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                  c = 1'b0;
               end
            end
         end
         bcdInc = r;
      end
   endfunction

   function [15:0] merge16;
      input [15:0] o;
      input [15:0] d;
      input [1:0]  s;
      begin
         merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   reg [15:0]        mem [0:MEM_WORDS-1];
   reg [15:0]        hist [0:HIST_WORDS-1];
   reg               awFull_ff, wFull_ff;
   reg [11:0]        awAddr_ff;
   reg [15:0]        wData_ff;
   reg [1:0]         wStrb_ff;
   reg [16:0]        exec_ff;
   reg [15:0]        ctrl_ff, source_ff, ncyc_ff;
   reg [16:0]        range_ff;
   reg [9:0]         minCode_ff, avgCode_ff;
   reg [15:0]        minRes_ff, minLoc_ff, avgRes_ff, avgPtr_ff;
   reg               fault_ff, zero_ff, sign_ff;
   reg [1:0]         state_ff;
   reg [MEM_AW-1:0]  idx_ff;
   reg [9:0]         left_ff;
   reg [15:0]        best_ff, bestLoc_ff, addr_ff, off_ff;
   reg [HIST_AW:0]   sumIdx_ff;
   reg [SUM_W-1:0]   quo_ff;
   reg [7:0]         rem_ff;
   reg [4:0]         divCnt_ff;
   reg [6:0]         nReg_ff;
   // The execution condition sits above the 16-bit write latch, so it is captured on its own.
   reg               wCond_ff;
   integer           k;

   // ****************************************************************
   // Decode and operand checks
   // ****************************************************************
   wire              doWr     = awFull_ff && wFull_ff && !s_axi_bvalid;
   wire              memWrHit = (awAddr_ff[11:8] == `MRA_MEM_PAGE) &&
                                ({1'b0, awAddr_ff[7:2]} < MEM_WORDS);
   wire              busy     = (state_ff != ST_IDLE);
   wire              execWr   = doWr && (awAddr_ff == `MRA_EXEC_OFS) && !busy;
   wire [15:0]       startBcd = range_ff[15:0];
   wire [13:0]       startBin = bcd2bin(startBcd);
   wire [13:0]       cntBin   = bcd2bin({4'h0, ctrl_ff[11:0]});
   wire [14:0]       endBin   = {1'b0, startBin} + {1'b0, cntBin} - 15'h0001;
   wire              cntOk    = isBcd({4'h0, ctrl_ff[11:0]}) && (ctrl_ff[11:0] != 12'h000);
   wire              minBad   = !isBcd(startBcd) || !cntOk ||
                                (endBin >= {8'h00, MEM_WORDS});
   wire [13:0]       nBin     = bcd2bin(ncyc_ff);
   wire              nOk      = isBcd(ncyc_ff) && (nBin != 14'h0000) && (nBin <= `MRA_NCYC_MAX);
   wire [13:0]       pBin     = bcd2bin({8'h00, avgPtr_ff[7:0]});
   wire [HIST_AW-1:0] pIdx    = pBin[HIST_AW-1:0];
   wire              lastSlot = (pBin == nBin - 14'h0001);
   wire [15:0]       ptrInc   = bcdInc({8'h00, avgPtr_ff[7:0]});
   wire [15:0]       startInc = bcdInc(startBcd);
   wire [15:0]       addrInc  = bcdInc(addr_ff);
   wire [15:0]       offInc   = bcdInc(off_ff);
   wire              runMin   = execWr && wCond_ff &&
                                (wData_ff[9:0] == minCode_ff);
   wire              runAvg   = execWr && wCond_ff &&
                                (wData_ff[9:0] == avgCode_ff);
   wire              histWe   = runAvg && nOk;
   wire              sgn      = ctrl_ff[`MRA_CTRL_SIGNED_BIT];
   wire [15:0]       cand     = mem[idx_ff];
   wire              candLess = {cand[15] ^ sgn, cand[14:0]} < {best_ff[15] ^ sgn, best_ff[14:0]};
   wire [7:0]        trial    = {rem_ff[6:0], quo_ff[SUM_W-1]};

   // ****************************************************************
   // AXI4-Lite handshakes
   // ****************************************************************
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         awFull_ff     <= 1'b0;
         wFull_ff      <= 1'b0;
         awAddr_ff     <= 12'h000;
         wData_ff      <= 16'h0000;
         wStrb_ff      <= 2'h0;
         wCond_ff      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `MRA_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `MRA_RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awFull_ff     <= 1'b1;
            awAddr_ff     <= {s_axi_awaddr[11:2], 2'h0};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wFull_ff     <= 1'b1;
            wData_ff     <= s_axi_wdata[15:0];
            wStrb_ff     <= s_axi_wstrb[1:0];
            wCond_ff     <= s_axi_wdata[`MRA_EXEC_COND_BIT] && s_axi_wstrb[2];
            s_axi_wready <= 1'b0;
         end
         if (doWr)
         begin
            awFull_ff    <= 1'b0;
            wFull_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_ff <= `MRA_AVGPTR_OFS || memWrHit ||
                             awAddr_ff[11:8] == `MRA_HIST_PAGE) ? `MRA_RESP_OKAY : `MRA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `MRA_RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            case ({s_axi_araddr[11:2], 2'h0})
               `MRA_EXEC_OFS:    s_axi_rdata <= {15'h0000, exec_ff};
               `MRA_CTRL_OFS:    s_axi_rdata[15:0] <= ctrl_ff;
               `MRA_RANGE_OFS:   s_axi_rdata <= {15'h0000, range_ff};
               `MRA_SOURCE_OFS:  s_axi_rdata[15:0] <= source_ff;
               `MRA_NCYC_OFS:    s_axi_rdata[15:0] <= ncyc_ff;
               `MRA_MINRES_OFS:  s_axi_rdata[15:0] <= minRes_ff;
               `MRA_MINLOC_OFS:  s_axi_rdata[15:0] <= minLoc_ff;
               `MRA_STATUS_OFS:  s_axi_rdata[3:0] <= {busy, sign_ff, zero_ff, fault_ff};
               `MRA_MINCODE_OFS: s_axi_rdata[9:0] <= minCode_ff;
               `MRA_AVGCODE_OFS: s_axi_rdata[9:0] <= avgCode_ff;
               `MRA_AVGRES_OFS:  s_axi_rdata[15:0] <= avgRes_ff;
               `MRA_AVGPTR_OFS:  s_axi_rdata[15:0] <= avgPtr_ff;
               default:
               begin
                  if (s_axi_araddr[11:8] == `MRA_MEM_PAGE && {1'b0, s_axi_araddr[7:2]} < MEM_WORDS)
                     s_axi_rdata[15:0] <= mem[s_axi_araddr[MEM_AW+1:2]];
                  else if (s_axi_araddr[11:8] == `MRA_HIST_PAGE &&
                           {1'b0, s_axi_araddr[7:2]} < HIST_WORDS)
                     s_axi_rdata[15:0] <= hist[s_axi_araddr[HIST_AW+1:2]];
                  else
                     s_axi_rresp <= `MRA_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Word memory and history buffer
   // ****************************************************************
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (k = 0; k < MEM_WORDS; k = k + 1)
            mem[k] <= 16'h0000;
         for (k = 0; k < HIST_WORDS; k = k + 1)
            hist[k] <= 16'h0000;
      end
      else
      begin
         if (doWr && memWrHit)
            mem[awAddr_ff[MEM_AW+1:2]] <= merge16(mem[awAddr_ff[MEM_AW+1:2]], wData_ff, wStrb_ff);
         if (histWe)
            hist[pIdx] <= source_ff;
      end
   end

   // ****************************************************************
   // Configuration registers and execution engine
   // ****************************************************************
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         exec_ff    <= 17'h00000;
         ctrl_ff    <= 16'h0000;
         range_ff   <= 17'h00000;
         source_ff  <= 16'h0000;
         ncyc_ff    <= `MRA_NCYC_RST;
         minCode_ff <= `MRA_MINCODE_RST;
         avgCode_ff <= `MRA_AVGCODE_RST;
         minRes_ff  <= 16'h0000;
         minLoc_ff  <= 16'h0000;
         avgRes_ff  <= 16'h0000;
         avgPtr_ff  <= 16'h0000;
         fault_ff   <= 1'b0;
         zero_ff    <= 1'b0;
         sign_ff    <= 1'b0;
         state_ff   <= ST_IDLE;
         idx_ff     <= {MEM_AW{1'b0}};
         left_ff    <= 10'h000;
         best_ff    <= 16'h0000;
         bestLoc_ff <= 16'h0000;
         addr_ff    <= 16'h0000;
         off_ff     <= 16'h0000;
         sumIdx_ff  <= {(HIST_AW+1){1'b0}};
         quo_ff     <= {SUM_W{1'b0}};
         rem_ff     <= 8'h00;
         divCnt_ff  <= 5'h00;
         nReg_ff    <= 7'h00;
      end
      else
      begin
         if (doWr && !busy)
         begin
            case (awAddr_ff)
               `MRA_EXEC_OFS:    exec_ff <= {wCond_ff, 6'h00, wData_ff[9:0]};
               `MRA_CTRL_OFS:    ctrl_ff <= merge16(ctrl_ff, wData_ff, wStrb_ff);
               `MRA_RANGE_OFS:   range_ff <= {wCond_ff, merge16(range_ff[15:0], wData_ff, wStrb_ff)};
               `MRA_SOURCE_OFS:  source_ff <= merge16(source_ff, wData_ff, wStrb_ff);
               `MRA_NCYC_OFS:    ncyc_ff <= merge16(ncyc_ff, wData_ff, wStrb_ff);
               `MRA_MINCODE_OFS: minCode_ff <= wData_ff[9:0];
               `MRA_AVGCODE_OFS: avgCode_ff <= wData_ff[9:0];
               default:          exec_ff <= exec_ff;
            endcase
         end
         case (state_ff)
            ST_IDLE:
            begin
               if (runMin && minBad)
                  fault_ff <= 1'b1;
               else if (runMin)
               begin
                  fault_ff   <= 1'b0;
                  state_ff   <= ST_MIN;
                  best_ff    <= mem[startBin[MEM_AW-1:0]];
                  bestLoc_ff <= range_ff[`MRA_RANGE_DM_BIT] ? startBcd : 16'h0000;
                  idx_ff     <= startBin[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, 1'b1};
                  addr_ff    <= startInc;
                  off_ff     <= 16'h0001;
                  left_ff    <= cntBin[9:0] - 10'h001;
               end
               if (runAvg && !nOk)
                  fault_ff <= 1'b1;
               else if (runAvg)
               begin
                  fault_ff <= 1'b0;
                  nReg_ff  <= nBin[6:0];
                  if (!avgPtr_ff[`MRA_PTR_VALID_BIT] && !lastSlot)
                  begin
                     avgRes_ff <= source_ff;
                     avgPtr_ff <= {8'h00, ptrInc[7:0]};
                  end
                  else
                  begin
                     avgPtr_ff <= {1'b1, 7'h00, lastSlot ? 8'h00 : ptrInc[7:0]};
                     state_ff  <= ST_SUM;
                     sumIdx_ff <= {(HIST_AW+1){1'b0}};
                     quo_ff    <= {SUM_W{1'b0}};
                  end
               end
            end
            ST_MIN:
            begin
               if (left_ff == 10'h000)
               begin
                  minRes_ff <= best_ff;
                  if (ctrl_ff[`MRA_CTRL_LOC_BIT])
                     minLoc_ff <= bestLoc_ff;
                  zero_ff  <= (best_ff == 16'h0000);
                  sign_ff  <= best_ff[15];
                  state_ff <= ST_IDLE;
               end
               else
               begin
                  if (candLess)
                  begin
                     best_ff    <= cand;
                     bestLoc_ff <= range_ff[`MRA_RANGE_DM_BIT] ? addr_ff : off_ff;
                  end
                  idx_ff  <= idx_ff + {{(MEM_AW-1){1'b0}}, 1'b1};
                  addr_ff <= addrInc;
                  off_ff  <= offInc;
                  left_ff <= left_ff - 10'h001;
               end
            end
            ST_SUM:
            begin
               if (sumIdx_ff == nReg_ff[HIST_AW:0])
               begin
                  state_ff  <= ST_DIV;
                  rem_ff    <= 8'h00;
                  divCnt_ff <= 5'h00;
               end
               else
               begin
                  quo_ff    <= quo_ff + {{HIST_AW{1'b0}}, hist[sumIdx_ff[HIST_AW-1:0]]};
                  sumIdx_ff <= sumIdx_ff + {{HIST_AW{1'b0}}, 1'b1};
               end
            end
            ST_DIV:
            begin
               if (trial >= {1'b0, nReg_ff})
               begin
                  rem_ff <= trial - {1'b0, nReg_ff};
                  quo_ff <= {quo_ff[SUM_W-2:0], 1'b1};
               end
               else
               begin
                  rem_ff <= trial;
                  quo_ff <= {quo_ff[SUM_W-2:0], 1'b0};
               end
               divCnt_ff <= divCnt_ff + 5'h01;
               if (divCnt_ff == SUM_W[4:0] - 5'h01)
               begin
                  avgRes_ff <= trial >= {1'b0, nReg_ff} ? {quo_ff[14:0], 1'b1}
                                                         : {quo_ff[14:0], 1'b0};
                  state_ff  <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
endmodule // mra_min_avg

// *** bench/mra_min_avg_checker.sv ***
/*
 Bus-level assertions for the min/average unit.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module mra_min_avg_checker (
   input logic        clk,
   input logic        arst_n,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   chk_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_write_blocked: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   chk_bresp_legal: assert property (
      s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
   chk_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_read_blocked: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:17] == 15'h0000) else $error("upper bits set");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule // mra_min_avg_checker

bind mra_min_avg mra_min_avg_checker i_chk (.*);

// *** bench/mra_prog_model.sv ***
/*
 User-program model: an AXI4-Lite master that hands operands to the unit.
 Assumes a single clock and one transfer at a time.
*/
`timescale 1ns/1ps
// ****************************************************************
// Program side master
// ****************************************************************
module mra_prog_model (
   input  logic        clk,
   output logic [11:0] s_axi_awaddr,
   output logic        s_axi_awvalid,
   input  logic        s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0]  s_axi_wstrb,
   output logic        s_axi_wvalid,
   input  logic        s_axi_wready,
   input  logic [1:0]  s_axi_bresp,
   input  logic        s_axi_bvalid,
   output logic        s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic        s_axi_arvalid,
   input  logic        s_axi_arready,
   input  logic [31:0] s_axi_rdata,
   input  logic [1:0]  s_axi_rresp,
   input  logic        s_axi_rvalid,
   output logic        s_axi_rready
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // Released payloads are inverted so that a stale value is never mistaken for live data.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!done)
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
         if (s_axi_bvalid)
         begin
            done = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!done)
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
         if (s_axi_rvalid)
         begin
            done = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
endmodule // mra_prog_model

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the min/average unit.
 Assumes the program model drives the register bus.
*/
`timescale 1ns/1ps
// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cyc = 0;
   always #20 clk = ~clk;
   mra_min_avg i_dut (.*);
   mra_prog_model i_prog (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      i_prog.wr(a, d, r);
      chk(r, 2'h0);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      i_prog.rd(a, d, r);
      chk(d, e);
   endtask
   task automatic run_op(input logic [31:0] ex);
      logic [31:0] d;
      logic [1:0]  r;
      wr(12'h000, ex);
      d = 32'h8;
      repeat (200) if (d[3] !== 1'b0) i_prog.rd(12'h01C, d, r);
      chk({31'h0, d[3]}, 32'h0);
   endtask
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rdchk(12'h020, 32'h0B7);
      rdchk(12'h024, 32'h0C3);
      i_prog.rd(12'h0F0, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, 32'h2);
   endtask
   task automatic t_min;
      logic [15:0] mem [0:6] = '{16'h5, 16'h3, 16'h8000, 16'h3, 16'h7, 16'h0, 16'h9};
      for (int i = 0; i < 7; i++) wr(12'h100 + 12'(4 * i), {16'h0, mem[i]});
      wr(12'h004, 32'h4004);
      wr(12'h008, 32'h00001);
      run_op(32'h1_00B7);
      rdchk(12'h014, 32'h3);
      rdchk(12'h018, 32'h0);
      wr(12'h004, 32'hC004);
      run_op(32'h0_00B7);
      rdchk(12'h014, 32'h3);
      wr(12'h008, 32'h10001);
      run_op(32'h1_00B7);
      rdchk(12'h014, 32'h8000);
      rdchk(12'h018, 32'h2);
      rdchk(12'h01C, 32'h4);
      wr(12'h004, 32'h4006);
      wr(12'h008, 32'h00000);
      run_op(32'h1_00B7);
      rdchk(12'h014, 32'h0);
      rdchk(12'h018, 32'h5);
      rdchk(12'h01C, 32'h2);
      wr(12'h004, 32'h0004);
      wr(12'h008, 32'h00001);
      run_op(32'h1_00B7);
      rdchk(12'h018, 32'h5);
      rdchk(12'h01C, 32'h0);
      wr(12'h004, 32'h400A);
      run_op(32'h1_00B7);
      rdchk(12'h01C, 32'h1);
   endtask
   task automatic t_avg;
      logic [15:0] src [0:3] = '{16'd6, 16'd9, 16'd12, 16'd4};
      logic [15:0] res [0:3] = '{16'd6, 16'd9, 16'd9, 16'd8};
      logic [15:0] ptr [0:3] = '{16'h1, 16'h2, 16'h8000, 16'h8001};
      wr(12'h010, 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         wr(12'h00C, {16'h0, src[i]});
         run_op(32'h1_00C3);
         rdchk(12'h028, {16'h0, res[i]});
         rdchk(12'h02C, {16'h0, ptr[i]});
      end
      rdchk(12'h200, 32'd4);
      rdchk(12'h208, 32'd12);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The limit is far above the few hundred cycles the sequence needs.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_min();
      t_avg();
      end_of_test();
   end
endmodule // tb_top
